// [alsup_pkg.sv]
// Notes on behaviour
// - With compensation on, offset added moving positive, removed moving negative, at set slew.
// - Positive and negative limit watching are enabled separately.
// - Active-low option makes a low input mean limit contact; otherwise high.
// - Each limit watches a configured input bit; bits 12 to 19 are recommended.
// - Several limits may name the same input bit.
// - Kill-drive action disables the axis while the limit is present.
// - Kill-drive action refuses re-enable while the limit remains present.
// - Disallow action disables only when moving into the limit; re-enable and retreat allowed.
// - Stop action keeps the axis enabled and raises motion hold.
// - Hold decelerates jogs and coordinated moves to a stop.
// - Hold stays and blocks motion until software clears it.
// - After clearing, motion into the limit raises a new hold; standstill or retreat allowed.
// - Soft limits behave like a hardware limit with the stop action.
// - Soft limits always apply; disable them only by a huge range.
`default_nettype none
package alsup_pkg;
   localparam int IN_W   = 32;
   localparam int POS_W  = 32;
   localparam int BIT_W  = 5;
   localparam int AXI_AW = 6;

   localparam logic [AXI_AW-1:0] REG_CTRL    = 6'h00;
   localparam logic [AXI_AW-1:0] REG_LIMCFG  = 6'h04;
   localparam logic [AXI_AW-1:0] REG_OFFSET  = 6'h08;
   localparam logic [AXI_AW-1:0] REG_SLEW    = 6'h0c;
   localparam logic [AXI_AW-1:0] REG_SOFTPOS = 6'h10;
   localparam logic [AXI_AW-1:0] REG_SOFTNEG = 6'h14;
   localparam logic [AXI_AW-1:0] REG_STATUS  = 6'h18;
   localparam logic [AXI_AW-1:0] REG_IRQ     = 6'h1c;
   localparam logic [AXI_AW-1:0] REG_MASK    = 6'h20;
   localparam logic [AXI_AW-1:0] REG_OUTPOS  = 6'h24;

   // CTRL fields
   localparam int CTRL_COMP_EN  = 0;
   localparam int CTRL_AXIS_EN  = 1;
   localparam int CTRL_HOLD_CLR = 2;
   // LIMCFG fields
   localparam int LIM_POS_WATCH = 0;
   localparam int LIM_POS_LOW   = 1;
   localparam int LIM_POS_ACT   = 2;
   localparam int LIM_POS_BIT   = 4;
   localparam int LIM_NEG_WATCH = 16;
   localparam int LIM_NEG_LOW   = 17;
   localparam int LIM_NEG_ACT   = 18;
   localparam int LIM_NEG_BIT   = 20;

   // Interrupt event bits
   localparam int EV_POS_HIT = 0;
   localparam int EV_NEG_HIT = 1;
   localparam int EV_KILL    = 2;
   localparam int EV_HOLD    = 3;
   localparam int EV_W       = 4;

   // STATUS fields
   localparam int ST_POS_HIT = 0;
   localparam int ST_NEG_HIT = 1;
   localparam int ST_AXIS_EN = 3;
   localparam int ST_KILL    = 4;
   localparam int ST_HOLD    = 5;

   localparam logic [31:0] SOFTPOS_RST = 32'h7fffffff;
   localparam logic [31:0] SOFTNEG_RST = 32'h80000000;
   localparam logic [31:0] SLEW_RST    = 32'h00000001;

   // Servo period 90 us at 250 MHz
   localparam int CLK_MHZ       = 250;
   localparam int SERVO_US      = 90;
   localparam int SERVO_CYC     = SERVO_US * CLK_MHZ;
   localparam int SERVO_CNT_W   = 15;

   typedef enum logic [1:0] {
      ALSUP_ACT_KILL     = 2'h0,
      ALSUP_ACT_DISALLOW = 2'h1,
      ALSUP_ACT_STOP     = 2'h2
   } alsup_act_e;

   typedef struct packed {
      logic             watch;
      logic             act_low;
      alsup_act_e       action;
      logic [BIT_W-1:0] bit_no;
   } alsup_lim_s;
endpackage
`default_nettype wire

// [alsup_top.sv]
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
module alsup_top (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [alsup_pkg::IN_W-1:0] dig_in,
   input  wire logic signed [31:0]         cmd_pos,
   input  wire logic                       axis_en_req,
   input  wire logic [5:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [5:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic signed [31:0]              out_pos,
   output logic                            axis_enabled,
   output logic                            motion_hold,
   output logic                            servo_tick,
   output logic                            irq
);
   logic                   rst_meta_r;
   logic                   rst_sync_r;
   logic [alsup_pkg::SERVO_CNT_W-1:0] tick_cnt_r;
   logic [31:0]            ctrl_r;
   logic [31:0]            limcfg_r;
   logic signed [31:0]     offset_r;
   logic [31:0]            slew_r;
   logic signed [31:0]     softpos_r;
   logic signed [31:0]     softneg_r;
   logic [alsup_pkg::EV_W-1:0] irq_r;
   logic [alsup_pkg::EV_W-1:0] mask_r;
   logic signed [31:0]     comp_r;
   logic signed [31:0]     prev_pos_r;
   logic                   pos_hit_r;
   logic                   neg_hit_r;
   logic                   kill_r;
   logic                   hold_r;
   logic                   aw_got_r;
   logic                   w_got_r;
   logic [5:0]             aw_addr_r;
   logic [31:0]            wdata_r;
   logic [3:0]             wstrb_r;
   alsup_pkg::alsup_lim_s  lim_pos;
   alsup_pkg::alsup_lim_s  lim_neg;
   logic                   pos_raw;
   logic                   neg_raw;
   logic                   mv_pos;
   logic                   mv_neg;
   logic                   soft_pos;
   logic                   soft_neg;
   logic                   stop_pos;
   logic                   stop_neg;
   logic                   kill_cond;
   logic                   hold_set;
   logic                   hold_clr;
   logic                   wr_fire;
   logic [alsup_pkg::EV_W-1:0] ev;
   logic signed [31:0]     comp_goal;
   logic [31:0]            comp_gap;
   logic [31:0]            status_w;

   function automatic alsup_pkg::alsup_lim_s lim_field(input logic [15:0] f);
      alsup_pkg::alsup_lim_s s;
      s.watch   = f[alsup_pkg::LIM_POS_WATCH];
      s.act_low = f[alsup_pkg::LIM_POS_LOW];
      s.action  = alsup_pkg::alsup_act_e'(f[alsup_pkg::LIM_POS_ACT +: 2]);
      s.bit_no  = f[alsup_pkg::LIM_POS_BIT +: alsup_pkg::BIT_W];
      return s;
   endfunction

   // Contact level check, shared by both limits
   function automatic logic contact(input alsup_pkg::alsup_lim_s s,
                                    input logic [alsup_pkg::IN_W-1:0] din);
      logic lvl;
      lvl = din[s.bit_no];
      return s.watch && (s.act_low ? !lvl : lvl);
   endfunction

   // Hit of one limit qualified by its configured action
   function automatic logic hit_act(input logic                  hit,
                                    input alsup_pkg::alsup_lim_s s,
                                    input alsup_pkg::alsup_act_e a);
      return hit && s.action == a;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Two flops so reset removal never lands mid-cycle on the logic below
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         tick_cnt_r <= '0;
         servo_tick <= 1'b0;
      end else if (tick_cnt_r ==
                   alsup_pkg::SERVO_CNT_W'(alsup_pkg::SERVO_CYC - 1)) begin
         tick_cnt_r <= '0;
         servo_tick <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + alsup_pkg::SERVO_CNT_W'(1);
         servo_tick <= 1'b0;
      end
   end

   assign lim_pos = lim_field(limcfg_r[15:0]);
   assign lim_neg = lim_field(limcfg_r[31:16]);
   assign pos_raw = contact(lim_pos, dig_in);
   assign neg_raw = contact(lim_neg, dig_in);
   // Direction is the move since the previous tick
   assign mv_pos  = cmd_pos > prev_pos_r;
   assign mv_neg  = cmd_pos < prev_pos_r;
   assign soft_pos = cmd_pos > softpos_r;
   assign soft_neg = cmd_pos < softneg_r;

   // soft limits act as stop action
   assign stop_pos = soft_pos || hit_act(pos_hit_r, lim_pos, alsup_pkg::ALSUP_ACT_STOP);
   assign stop_neg = soft_neg || hit_act(neg_hit_r, lim_neg, alsup_pkg::ALSUP_ACT_STOP);

   assign kill_cond =
      hit_act(pos_hit_r, lim_pos, alsup_pkg::ALSUP_ACT_KILL) ||
      hit_act(neg_hit_r, lim_neg, alsup_pkg::ALSUP_ACT_KILL) ||
      (hit_act(pos_hit_r, lim_pos, alsup_pkg::ALSUP_ACT_DISALLOW) && mv_pos) ||
      (hit_act(neg_hit_r, lim_neg, alsup_pkg::ALSUP_ACT_DISALLOW) && mv_neg);

   // new hold only on motion toward the limit
   assign hold_set = servo_tick && ((stop_pos && mv_pos) || (stop_neg && mv_neg));
   assign wr_fire  = aw_got_r && w_got_r && !s_axi_bvalid;
   assign hold_clr = wr_fire && aw_addr_r == alsup_pkg::REG_CTRL &&
                     wstrb_r[0] && wdata_r[alsup_pkg::CTRL_HOLD_CLR];

   // sample inputs once per servo tick
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pos_hit_r  <= 1'b0;
         neg_hit_r  <= 1'b0;
         prev_pos_r <= '0;
      end else if (servo_tick) begin
         pos_hit_r  <= pos_raw;
         neg_hit_r  <= neg_raw;
         prev_pos_r <= cmd_pos;
      end
   end

   // Latched so the drive stays off between ticks until the host lets go
   // kill latched until limit clears and enable request is dropped
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         kill_r <= 1'b0;
      end else if (servo_tick && kill_cond) begin
         kill_r <= 1'b1;
      end else if (!kill_cond && !axis_en_req) begin
         kill_r <= 1'b0;
      end
   end
   // stop action leaves the axis enabled
   assign axis_enabled = axis_en_req && ctrl_r[alsup_pkg::CTRL_AXIS_EN] && !kill_r && !kill_cond;

   // hold sticks until cleared; set wins over clear
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         hold_r <= 1'b0;
      end else if (hold_set) begin
         hold_r <= 1'b1;
      end else if (hold_clr) begin
         hold_r <= 1'b0;
      end
   end
   // trajectory generator decelerates while this is high
   assign motion_hold = hold_r;

   // offset slews toward goal by direction
   assign comp_goal = !ctrl_r[alsup_pkg::CTRL_COMP_EN] ? 32'sh0 :
                      mv_pos ? offset_r : mv_neg ? 32'sh0 : comp_r;
   assign comp_gap  = 32'(comp_goal - comp_r);
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         comp_r  <= '0;
         out_pos <= '0;
      end else if (servo_tick) begin
         if (comp_goal > comp_r) begin
            comp_r <= ($signed(comp_gap) > $signed(slew_r)) ? 32'(comp_r + slew_r) : comp_goal;
         end else if (comp_goal < comp_r) begin
            comp_r <= ($signed(-comp_gap) > $signed(slew_r)) ? 32'(comp_r - slew_r) : comp_goal;
         end
         out_pos <= 32'(cmd_pos + comp_r);
      end
   end

   // Events by their named bit positions
   always_comb begin
      ev                        = '0;
      ev[alsup_pkg::EV_POS_HIT] = servo_tick && pos_raw;
      ev[alsup_pkg::EV_NEG_HIT] = servo_tick && neg_raw;
      ev[alsup_pkg::EV_KILL]    = servo_tick && kill_cond;
      ev[alsup_pkg::EV_HOLD]    = hold_set;
   end
   assign irq = |(irq_r & mask_r);

   // AXI4-Lite write: address and data in either order
   assign s_axi_awready = !aw_got_r;
   assign s_axi_wready  = !w_got_r;
   assign s_axi_bresp   = 2'b00;
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         aw_got_r     <= 1'b0;
         w_got_r      <= 1'b0;
         aw_addr_r    <= '0;
         wdata_r      <= '0;
         wstrb_r      <= '0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && !aw_got_r) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_got_r) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ctrl_r    <= '0;
         limcfg_r  <= '0;
         offset_r  <= '0;
         slew_r    <= alsup_pkg::SLEW_RST;
         softpos_r <= alsup_pkg::SOFTPOS_RST;
         softneg_r <= alsup_pkg::SOFTNEG_RST;
         mask_r    <= '0;
      end else if (wr_fire) begin
         unique case (aw_addr_r)
            alsup_pkg::REG_CTRL: begin
               ctrl_r <= merge(ctrl_r, wdata_r & 32'h00000003, wstrb_r);
            end
            alsup_pkg::REG_LIMCFG:  limcfg_r  <= merge(limcfg_r, wdata_r, wstrb_r);
            alsup_pkg::REG_OFFSET:  offset_r  <= merge(offset_r, wdata_r, wstrb_r);
            alsup_pkg::REG_SLEW:    slew_r    <= merge(slew_r, wdata_r, wstrb_r);
            alsup_pkg::REG_SOFTPOS: softpos_r <= merge(softpos_r, wdata_r, wstrb_r);
            alsup_pkg::REG_SOFTNEG: softneg_r <= merge(softneg_r, wdata_r, wstrb_r);
            alsup_pkg::REG_MASK: begin
               mask_r <= wstrb_r[0] ? wdata_r[alsup_pkg::EV_W-1:0] : mask_r;
            end
            default: ;
         endcase
      end
   end

   // Sticky events: a new event wins over a write-one clear
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         irq_r <= '0;
      end else if (wr_fire && aw_addr_r == alsup_pkg::REG_IRQ && wstrb_r[0]) begin
         irq_r <= (irq_r & ~wdata_r[alsup_pkg::EV_W-1:0]) | ev;
      end else begin
         irq_r <= irq_r | ev;
      end
   end

   // Status word from the named field positions; other bits read zero
   always_comb begin
      status_w                        = '0;
      status_w[alsup_pkg::ST_POS_HIT] = pos_hit_r;
      status_w[alsup_pkg::ST_NEG_HIT] = neg_hit_r;
      status_w[alsup_pkg::ST_AXIS_EN] = axis_enabled;
      status_w[alsup_pkg::ST_KILL]    = kill_r;
      status_w[alsup_pkg::ST_HOLD]    = hold_r;
   end

   // AXI4-Lite read, one cycle answer; unmapped reads zero with OKAY
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp   = 2'b00;
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         unique case (s_axi_araddr)
            alsup_pkg::REG_CTRL:    s_axi_rdata <= ctrl_r;
            alsup_pkg::REG_LIMCFG:  s_axi_rdata <= limcfg_r;
            alsup_pkg::REG_OFFSET:  s_axi_rdata <= offset_r;
            alsup_pkg::REG_SLEW:    s_axi_rdata <= slew_r;
            alsup_pkg::REG_SOFTPOS: s_axi_rdata <= softpos_r;
            alsup_pkg::REG_SOFTNEG: s_axi_rdata <= softneg_r;
            alsup_pkg::REG_STATUS:  s_axi_rdata <= status_w;
            alsup_pkg::REG_IRQ:     s_axi_rdata <= {28'h0, irq_r};
            alsup_pkg::REG_MASK:    s_axi_rdata <= {28'h0, mask_r};
            alsup_pkg::REG_OUTPOS:  s_axi_rdata <= comp_r;
            default:                s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [alsup_top_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module alsup_chk (
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               axis_en_req,
   input wire logic [1:0]         s_axi_rresp,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic signed [31:0] out_pos,
   input wire logic               axis_enabled,
   input wire logic               motion_hold,
   input wire logic               servo_tick
);
   int   gap_r;
   logic seen_r;

   // Spacing is judged only once a first tick has fixed the phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_r  <= 0;
         seen_r <= 1'b0;
      end else begin
         gap_r  <= servo_tick ? 1 : gap_r + 1;
         seen_r <= seen_r | servo_tick;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_tick_period : assert property (
      servo_tick && seen_r |-> gap_r == alsup_pkg::SERVO_CYC) else $error("tick spacing wrong");
   a_tick_pulse : assert property (
      servo_tick |=> !servo_tick) else $error("tick longer than one cycle");
   a_pos_on_tick : assert property (
      $changed(out_pos) |-> $past(servo_tick)) else $error("position moved off tick");
   a_hold_on_tick : assert property (
      $rose(motion_hold) |-> $past(servo_tick) || $past(servo_tick, 2))
      else $error("hold raised off tick");
   a_hold_sticky : assert property (
      $fell(motion_hold) |-> $rose(s_axi_bvalid)) else $error("hold dropped without a write");
   a_en_needs_req : assert property (
      axis_enabled |-> axis_en_req) else $error("axis enabled without request");
   a_bresp_stands : assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && s_axi_bresp == 2'h0)
      else $error("write response dropped");
   a_rdata_stands : assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_rresp_okay : assert property (
      s_axi_rvalid |-> s_axi_rresp == 2'h0) else $error("read response not okay");

   c_hold : cover property (motion_hold);
   c_hold_clear : cover property ($fell(motion_hold));
   c_kill : cover property (axis_en_req && !axis_enabled);
endmodule
`default_nettype wire

// [alsup_traj.sv]
`timescale 1ns/1ns
`default_nettype none
module alsup_traj (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  motion_hold,
   input  wire logic                  sw_hit,
   input  wire logic signed [31:0]    vel,
   output logic [alsup_pkg::IN_W-1:0] dig_in,
   output logic signed [31:0]         cmd_pos
);
   // Switch wired active low on input 12; unused inputs idle high
   always_comb begin
      dig_in     = 32'hffffffff;
      dig_in[12] = ~sw_hit;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_pos <= 32'sh0;
      end else if (!motion_hold) begin
         cmd_pos <= cmd_pos + vel;
      end
   end
endmodule
`default_nettype wire

// [test_axis_limit_backlash_supervisor.sv]
`timescale 1ns/1ns
`default_nettype none
module test_axis_limit_backlash_supervisor;
   logic                       clk, rst_n, axis_en_req, sw_hit, irq;
   logic                       axis_enabled, motion_hold, servo_tick;
   logic [alsup_pkg::IN_W-1:0] dig_in;
   logic signed [31:0]         cmd_pos, vel, out_pos, pos_at_tick;
   logic [5:0]                 s_axi_awaddr, s_axi_araddr;
   logic [31:0]                s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]                 s_axi_wstrb;
   logic [1:0]                 s_axi_bresp, s_axi_rresp;
   logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                       s_axi_rvalid, s_axi_rready;
   int                         miscompares, compares;
   localparam logic [37:0] ROWS [7] = '{
      {alsup_pkg::REG_CTRL, 32'h0}, {alsup_pkg::REG_SLEW, 32'h1},
      {alsup_pkg::REG_SOFTPOS, 32'h7fffffff}, {alsup_pkg::REG_SOFTNEG, 32'h80000000},
      {alsup_pkg::REG_IRQ, 32'h0}, {alsup_pkg::REG_MASK, 32'h0}, {6'h3c, 32'h0}};

   alsup_top dut_u (.clk, .rst_n, .dig_in, .cmd_pos, .axis_en_req, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .out_pos, .axis_enabled, .motion_hold, .servo_tick, .irq);
   alsup_traj traj_u (.clk, .rst_n, .motion_hold, .sw_hit, .vel, .dig_in, .cmd_pos);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Ready is read at the falling edge so the value equals what the rising edge sees
   task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
      int   n;
      logic ta, tw, bv;
      n = 0;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(negedge clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         bv = s_axi_bvalid;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         n++;
      end while (bv !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      if (bv !== 1'b1) miscompares++;
      @(negedge clk);
   endtask

   task automatic axi_rd(input logic [5:0] a, output logic [31:0] d);
      int   n;
      logic ta, rv;
      n = 0;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge clk);
         ta = s_axi_arvalid & s_axi_arready;
         rv = s_axi_rvalid;
         d  = s_axi_rdata;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'b0;
         n++;
      end while (rv !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      if (rv !== 1'b1) miscompares++;
      @(negedge clk);
   endtask

   task automatic wait_tick();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (servo_tick !== 1'b1 && n < 30000);
      if (n >= 30000) miscompares++;
      pos_at_tick = cmd_pos;
      @(posedge clk);
      @(negedge clk);
   endtask

   initial begin
      {rst_n, axis_en_req, sw_hit, vel} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      miscompares = 0;
      compares = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (ROWS[i]) begin
         axi_rd(ROWS[i][37:32], rd);
         chk(rd, ROWS[i][31:0]);
      end
      chk(32'(out_pos), 32'h0);
      chk(32'(motion_hold), 32'h0);
      axi_wr(alsup_pkg::REG_OFFSET, 32'h8);
      axi_wr(alsup_pkg::REG_SLEW, 32'h8);
      // Both limits share input 12: positive stops, negative disallows
      axi_wr(alsup_pkg::REG_LIMCFG, 32'h00c700cb);
      axi_wr(alsup_pkg::REG_CTRL, 32'h3);
      @(posedge clk);
      axis_en_req <= 1'b1;
      vel <= 32'sd5;
      @(negedge clk);
      chk(32'(axis_enabled), 32'h1);
      wait_tick();
      chk(32'(out_pos), 32'(pos_at_tick));
      axi_rd(alsup_pkg::REG_OUTPOS, rd);
      chk(rd, 32'h8);
      @(posedge clk);
      sw_hit <= 1'b1;
      wait_tick();
      wait_tick();
      chk(32'(out_pos), 32'(pos_at_tick + 32'sd8));
      chk(32'(motion_hold), 32'h1);
      chk(32'(axis_enabled), 32'h1);
      axi_rd(alsup_pkg::REG_STATUS, rd);
      chk(rd, 32'h2b);
      axi_rd(alsup_pkg::REG_IRQ, rd);
      chk(rd, 32'hb);
      chk(32'(irq), 32'h0);
      axi_wr(alsup_pkg::REG_MASK, 32'h8);
      chk(32'(irq), 32'h1);
      axi_wr(alsup_pkg::REG_IRQ, 32'h8);
      chk(32'(irq), 32'h0);
      axi_wr(alsup_pkg::REG_LIMCFG, 32'h00c700c3);
      axi_wr(alsup_pkg::REG_CTRL, 32'h7);
      chk(32'(motion_hold), 32'h0);
      wait_tick();
      chk(32'(axis_enabled), 32'h0);
      @(posedge clk);
      axis_en_req <= 1'b0;
      @(posedge clk);
      axis_en_req <= 1'b1;
      @(negedge clk);
      chk(32'(axis_enabled), 32'h0);
      axi_rd(alsup_pkg::REG_STATUS, rd);
      chk(32'(rd[4]), 32'h1);
      // Inside the negative limit: re-enable and retreat allowed, moving in refused
      axi_wr(alsup_pkg::REG_LIMCFG, 32'h00c700cb);
      @(posedge clk);
      axis_en_req <= 1'b0;
      @(posedge clk);
      axis_en_req <= 1'b1;
      @(negedge clk);
      chk(32'(axis_enabled), 32'h1);
      @(posedge clk);
      vel <= -32'sd5;
      repeat (300) @(posedge clk);
      @(negedge clk);
      chk(32'(axis_enabled), 32'h0);
      results();
   end

   initial begin
      repeat (96000) @(posedge clk);
      miscompares++;
      results();
   end
endmodule

bind alsup_top alsup_chk chk_u (.clk, .rst_n, .axis_en_req, .s_axi_rresp, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .out_pos,
   .axis_enabled, .motion_hold, .servo_tick);
`default_nettype wire
